// File: rlf_pkg.sv
/*
 * rlf_pkg: constants and carrier types for the per-port line statistics
 * and link clock detector register bank.
 * assumes: 8-bit register address/data from an upstream i2c target core.
 */
package rlf_pkg;
    localparam int NUM_PORTS = 4;
    localparam logic [7:0] OFS_PORT_SELECT = 8'h4c;
    localparam logic [7:0] OFS_LINES_HIGH = 8'h73;
    localparam logic [7:0] OFS_LINES_LOW = 8'h74;
    localparam logic [7:0] OFS_LEN_HIGH = 8'h75;
    localparam logic [7:0] OFS_LEN_LOW = 8'h76;
    localparam logic [7:0] OFS_DETECT_CTL = 8'h77;
    localparam logic [7:0] OFS_MBOX_FIRST = 8'h78;
    localparam logic [7:0] OFS_MBOX_SECOND = 8'h79;
    localparam logic [7:0] RST_DETECT_CTL = 8'hc5;
    localparam logic [7:0] RST_MBOX_FIRST = 8'h00;
    localparam logic [7:0] RST_MBOX_SECOND = 8'h01;
    localparam logic [7:0] RST_PORT_SELECT = 8'h01;
    localparam int HYST_MSB = 7;
    localparam int HYST_LSB = 6;
    localparam int STAB_MSB = 5;
    localparam int STAB_LSB = 4;
    localparam int LOWLIM_MSB = 3;
    localparam int LOWLIM_LSB = 0;
    localparam int CLK_MHZ = 200;
    localparam int STAB_TIME0_NS = 40000;
    localparam int STAB_TIME1_NS = 80000;
    localparam int STAB_TIME2_NS = 320000;
    localparam int STAB_TIME3_NS = 1280000;
    localparam int STAB_CYC0 = STAB_TIME0_NS * CLK_MHZ / 1000;
    localparam int STAB_CYC1 = STAB_TIME1_NS * CLK_MHZ / 1000;
    localparam int STAB_CYC2 = STAB_TIME2_NS * CLK_MHZ / 1000;
    localparam int STAB_CYC3 = STAB_TIME3_NS * CLK_MHZ / 1000;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } rlf_reg_req_s;

    typedef struct packed {
        logic frame_done;
        logic [15:0] lines;
        logic [15:0] length;
    } rlf_frame_stat_s;
endpackage

// File: rlf_bank.sv
/*
 * rlf_bank: per-receive-port line count, line length, clock detector
 * control and mailbox registers, selected by the port select register.
 * assumes: register requests are one-cycle strobes from a same-clock i2c
 * target core; frame stats and clock measurements are same-clock, one
 * measurement pulse per port carrying the measured frequency in mhz.
 */
`timescale 1ns/1ps
module rlf_bank
    import rlf_pkg::*;
#(
    parameter int PORTS = NUM_PORTS,
    parameter int STAB_COUNT0 = STAB_CYC0,
    parameter int STAB_COUNT1 = STAB_CYC1,
    parameter int STAB_COUNT2 = STAB_CYC2,
    parameter int STAB_COUNT3 = STAB_CYC3
) (
    input wire logic clk,
    input wire logic rst,
    input wire rlf_reg_req_s req,
    output logic [7:0] rdata,
    output logic rvalid,
    input wire rlf_frame_stat_s [PORTS-1:0] frame_stat,
    input wire logic [PORTS-1:0] frame_lines_change_irq_enable,
    input wire logic [PORTS-1:0] line_length_change_irq_enable,
    input wire logic [PORTS-1:0] freq_sample,
    input wire logic [PORTS-1:0][7:0] freq_mhz,
    output logic [PORTS-1:0][7:0] freq_held,
    output logic [PORTS-1:0] clock_stable,
    output logic [PORTS-1:0] link_clock_missing
);
    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    logic [7:0] port_select, next_port_select;
    logic [PORTS-1:0][15:0] lines, next_lines;
    logic [PORTS-1:0][15:0] length, next_length;
    logic [PORTS-1:0] lines_hold, next_lines_hold;
    logic [PORTS-1:0] length_hold, next_length_hold;
    logic [PORTS-1:0][7:0] lines_lo_latch, next_lines_lo_latch;
    logic [PORTS-1:0][7:0] length_lo_latch, next_length_lo_latch;
    logic [PORTS-1:0][7:0] detect_ctl, next_detect_ctl;
    logic [PORTS-1:0][7:0] mbox0, next_mbox0;
    logic [PORTS-1:0][7:0] mbox1, next_mbox1;
    logic [PORTS-1:0][7:0] next_freq_held;
    logic [PORTS-1:0][20:0] stab_cnt, next_stab_cnt;
    logic [PORTS-1:0] next_clock_stable, next_link_clock_missing;
    logic [7:0] next_rdata;
    logic next_rvalid;

    function automatic logic [20:0] stab_limit(input logic [1:0] code);
        case (code)
            2'h0: stab_limit = 21'(STAB_COUNT0);
            2'h1: stab_limit = 21'(STAB_COUNT1);
            2'h2: stab_limit = 21'(STAB_COUNT2);
            default: stab_limit = 21'(STAB_COUNT3);
        endcase
    endfunction

    function automatic logic sel_hit(input logic [7:0] ps, input int p);
        sel_hit = ps[p % 8];
    endfunction

    // ---------------------------------------------------------------
    // next state
    // ---------------------------------------------------------------
    always_comb begin
        logic [7:0] diff;
        logic [7:0] hyst;
        logic lines_take;
        logic len_take;
        diff = 8'h00;
        hyst = 8'h00;
        lines_take = 1'b0;
        len_take = 1'b0;
        next_port_select = port_select;
        next_lines = lines;
        next_length = length;
        next_lines_hold = lines_hold;
        next_length_hold = length_hold;
        next_lines_lo_latch = lines_lo_latch;
        next_length_lo_latch = length_lo_latch;
        next_detect_ctl = detect_ctl;
        next_mbox0 = mbox0;
        next_mbox1 = mbox1;
        next_freq_held = freq_held;
        next_stab_cnt = stab_cnt;
        next_clock_stable = clock_stable;
        next_link_clock_missing = link_clock_missing;
        next_rdata = 8'h00;
        next_rvalid = req.rd;
        if (req.wr && req.addr == OFS_PORT_SELECT) begin
            next_port_select = req.wdata;
        end
        for (int p = 0; p < PORTS; p++) begin
            // frame results land unless held awaiting a read while the change irq enable is set
            lines_take = frame_stat[p].frame_done &&
                !(lines_hold[p] && frame_lines_change_irq_enable[p]);
            len_take = frame_stat[p].frame_done &&
                !(length_hold[p] && line_length_change_irq_enable[p]);
            if (lines_take) begin
                next_lines[p] = frame_stat[p].lines;
            end
            if (len_take) begin
                next_length[p] = frame_stat[p].length;
            end
            if (sel_hit(port_select, p)) begin
                if (req.rd) begin
                    case (req.addr)
                        OFS_LINES_HIGH: begin
                            // freeze released by the read
                            next_lines_lo_latch[p] = lines[p][7:0];
                            next_lines_hold[p] = 1'b0;
                        end
                        OFS_LINES_LOW: next_lines_hold[p] = 1'b0;
                        OFS_LEN_HIGH: begin
                            next_length_lo_latch[p] = length[p][7:0];
                            next_length_hold[p] = 1'b0;
                        end
                        OFS_LEN_LOW: next_length_hold[p] = 1'b0;
                        default: ;
                    endcase
                end
                if (req.wr) begin
                    case (req.addr)
                        OFS_DETECT_CTL: next_detect_ctl[p] = req.wdata;
                        OFS_MBOX_FIRST: next_mbox0[p] = req.wdata;
                        OFS_MBOX_SECOND: next_mbox1[p] = req.wdata;
                        default: ;
                    endcase
                end
            end
            // an accepted frame marks the value unread; it beats a read
            // in the same cycle so the fresh value is never lost
            if (lines_take) begin
                next_lines_hold[p] = 1'b1;
            end
            if (len_take) begin
                next_length_hold[p] = 1'b1;
            end
            // frequency detector
            hyst = {6'h00, detect_ctl[p][HYST_MSB:HYST_LSB]};
            diff = (freq_mhz[p] > freq_held[p]) ? freq_mhz[p] - freq_held[p]
                                                : freq_held[p] - freq_mhz[p];
            if (freq_sample[p]) begin
                if (diff > hyst) begin
                    next_freq_held[p] = freq_mhz[p];
                    next_stab_cnt[p] = 21'h000000;
                    next_clock_stable[p] = 1'b0;
                end
                next_link_clock_missing[p] = freq_mhz[p] <
                    {4'h0, detect_ctl[p][LOWLIM_MSB:LOWLIM_LSB]};
            end
            if (!(freq_sample[p] && diff > hyst)) begin
                if (stab_cnt[p] >=
                    stab_limit(detect_ctl[p][STAB_MSB:STAB_LSB])) begin
                    next_clock_stable[p] = 1'b1;
                end else begin
                    next_stab_cnt[p] = stab_cnt[p] + 21'h000001;
                end
            end
        end
        // read data from the lowest selected port
        for (int p = PORTS - 1; p >= 0; p--) begin
            if (sel_hit(port_select, p)) begin
                case (req.addr)
                    OFS_LINES_HIGH: next_rdata = lines[p][15:8];
                    OFS_LINES_LOW: next_rdata = lines_lo_latch[p];
                    OFS_LEN_HIGH: next_rdata = length[p][15:8];
                    OFS_LEN_LOW: next_rdata = length_lo_latch[p];
                    OFS_DETECT_CTL: next_rdata = detect_ctl[p];
                    OFS_MBOX_FIRST: next_rdata = mbox0[p];
                    OFS_MBOX_SECOND: next_rdata = mbox1[p];
                    default: next_rdata = 8'h00;
                endcase
            end
        end
        if (req.addr == OFS_PORT_SELECT) begin
            next_rdata = port_select;
        end
        if (!req.rd) begin
            next_rdata = 8'h00;
        end
    end

    // ---------------------------------------------------------------
    // registers
    // ---------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            port_select <= RST_PORT_SELECT;
            lines <= '0;
            length <= '0;
            lines_hold <= '0;
            length_hold <= '0;
            lines_lo_latch <= '0;
            length_lo_latch <= '0;
            detect_ctl <= {PORTS{RST_DETECT_CTL}};
            mbox0 <= {PORTS{RST_MBOX_FIRST}};
            mbox1 <= {PORTS{RST_MBOX_SECOND}};
            freq_held <= '0;
            stab_cnt <= '0;
            clock_stable <= '0;
            link_clock_missing <= '0;
            rdata <= 8'h00;
            rvalid <= 1'b0;
        end else begin
            port_select <= next_port_select;
            lines <= next_lines;
            length <= next_length;
            lines_hold <= next_lines_hold;
            length_hold <= next_length_hold;
            lines_lo_latch <= next_lines_lo_latch;
            length_lo_latch <= next_length_lo_latch;
            detect_ctl <= next_detect_ctl;
            mbox0 <= next_mbox0;
            mbox1 <= next_mbox1;
            freq_held <= next_freq_held;
            stab_cnt <= next_stab_cnt;
            clock_stable <= next_clock_stable;
            link_clock_missing <= next_link_clock_missing;
            rdata <= next_rdata;
            rvalid <= next_rvalid;
        end
    end

    // ---------------------------------------------------------------
    // assertions (port 0)
    // ---------------------------------------------------------------
    lines_frozen_a: assert property (@(posedge clk) disable iff (rst)
        lines_hold[0] && frame_lines_change_irq_enable[0] &&
        !(req.rd && port_select[0]) |=> $stable(lines[0]))
        else $error("line count changed while frozen");
    lines_update_a: assert property (@(posedge clk) disable iff (rst)
        frame_stat[0].frame_done && !lines_hold[0]
        |=> lines[0] == $past(frame_stat[0].lines))
        else $error("line count not updated");
    len_frozen_a: assert property (@(posedge clk) disable iff (rst)
        length_hold[0] && line_length_change_irq_enable[0] &&
        !(req.rd && port_select[0]) |=> $stable(length[0]))
        else $error("line length changed while frozen");
    lines_latch_a: assert property (@(posedge clk) disable iff (rst)
        req.rd && port_select[0] && req.addr == OFS_LINES_HIGH
        |=> lines_lo_latch[0] == $past(lines[0][7:0]))
        else $error("line count low byte not latched");
    len_latch_a: assert property (@(posedge clk) disable iff (rst)
        req.rd && port_select[0] && req.addr == OFS_LEN_HIGH
        |=> length_lo_latch[0] == $past(length[0][7:0]))
        else $error("line length low byte not latched");
    high_read_a: assert property (@(posedge clk) disable iff (rst)
        req.rd && port_select == 8'h01 && req.addr == OFS_LINES_HIGH
        |=> rvalid && rdata == $past(lines[0][15:8]))
        else $error("line count high byte misread");
    mbox_read_a: assert property (@(posedge clk) disable iff (rst)
        req.wr && port_select == 8'h01 && req.addr == OFS_MBOX_SECOND
        ##2 req.rd && req.addr == OFS_MBOX_SECOND && port_select == 8'h01
        |=> rdata == $past(req.wdata, 3))
        else $error("mailbox readback wrong");
    clock_detect_hysteresis_a: assert property (@(posedge clk) disable iff (rst)
        freq_sample[0] && (freq_mhz[0] > freq_held[0] ?
        freq_mhz[0] - freq_held[0] : freq_held[0] - freq_mhz[0]) <=
        {6'h00, detect_ctl[0][7:6]} |=> $stable(freq_held[0]))
        else $error("frequency updated inside hysteresis");
    low_clock_a: assert property (@(posedge clk) disable iff (rst)
        freq_sample[0] |=> link_clock_missing[0] ==
        ($past(freq_mhz[0]) < {4'h0, $past(detect_ctl[0][3:0])}))
        else $error("missing clock flag wrong");
    stable_wait_a: assert property (@(posedge clk) disable iff (rst)
        $rose(clock_stable[0]) |-> stab_cnt[0] >=
        stab_limit(detect_ctl[0][5:4]))
        else $error("clock declared stable too early");
endmodule

// File: rlf_host.sv
/*
 * rlf_host: register host model that issues one-cycle read and write
 * strobes on the bank's request struct and collects read answers.
 * assumes: same clock as the bank, strobes launched at the falling edge.
 */
`timescale 1ns/1ps
module rlf_host
    import rlf_pkg::*;
(
    input wire logic clk,
    output rlf_reg_req_s req,
    input wire logic [7:0] rdata,
    input wire logic rvalid
);
    initial req = '0;

    // ------------------------------------------------------------
    // access tasks
    // ------------------------------------------------------------
    // released address and data are inverted so stale values never match
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        req <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
        @(negedge clk);
        req <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        d = 8'hxx;
        @(negedge clk);
        req <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
        @(negedge clk);
        req <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: 8'hff};
        for (int i = 0; i < 4; i++) begin
            if (rvalid === 1'b1) begin
                d = rdata;
                break;
            end
            @(posedge clk);
            #1;
        end
    endtask
endmodule

// File: tb_top.sv
/*
 * tb_top: directed test of the per-port line statistics and clock detect
 * register bank through its strobe register interface.
 * assumes: small stability counts 4/8/16/32 cycles, four ports.
 */
`timescale 1ns/1ps
module tb_top
    import rlf_pkg::*;
;
    logic clk;
    logic rst;
    rlf_reg_req_s req;
    logic [7:0] rdata;
    logic rvalid;
    rlf_frame_stat_s [3:0] frame_stat;
    logic [3:0] lines_ie;
    logic [3:0] len_ie;
    logic [3:0] freq_sample;
    logic [3:0][7:0] freq_mhz;
    logic [3:0][7:0] freq_held;
    logic [3:0] clock_stable;
    logic [3:0] link_clock_missing;
    int n_errors = 0;
    int checks_done = 0;

    rlf_bank #(.PORTS(4), .STAB_COUNT0(4), .STAB_COUNT1(8),
        .STAB_COUNT2(16), .STAB_COUNT3(32)) i_rlf_bank (
        .clk(clk), .rst(rst), .req(req), .rdata(rdata), .rvalid(rvalid),
        .frame_stat(frame_stat), .frame_lines_change_irq_enable(lines_ie),
        .line_length_change_irq_enable(len_ie), .freq_sample(freq_sample),
        .freq_mhz(freq_mhz), .freq_held(freq_held),
        .clock_stable(clock_stable), .link_clock_missing(link_clock_missing));

    rlf_host i_rlf_host (.clk(clk), .req(req), .rdata(rdata),
        .rvalid(rvalid));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic rc(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        i_rlf_host.rd(a, d);
        check(d, exp);
    endtask

    task automatic frame(input int p, input logic [15:0] l,
        input logic [15:0] n);
        @(negedge clk);
        frame_stat[p] <= '{frame_done: 1'b1, lines: l, length: n};
        @(negedge clk);
        frame_stat[p] <= '{frame_done: 1'b0, lines: ~l, length: ~n};
    endtask

    task automatic samp(input logic [7:0] f);
        @(negedge clk);
        freq_sample[0] <= 1'b1;
        freq_mhz[0] <= f;
        @(negedge clk);
        freq_sample[0] <= 1'b0;
        freq_mhz[0] <= ~f;
        @(negedge clk);
    endtask

    task automatic finish_test();
        $display("checks=%0d errors=%0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    initial begin
        #100000;
        n_errors++;
        finish_test();
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        rst = 1'b1;
        frame_stat = '0;
        lines_ie = '0;
        len_ie = '0;
        freq_sample = '0;
        freq_mhz = '0;
        repeat (8) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        rc(OFS_DETECT_CTL, 8'hc5);
        rc(OFS_MBOX_FIRST, 8'h00);
        rc(OFS_MBOX_SECOND, 8'h01);
        rc(OFS_PORT_SELECT, 8'h01);
        for (int a = 8'h73; a <= 8'h76; a++) rc(a[7:0], 8'h00);
        rc(8'h10, 8'h00);
        // separate copies per port, read-only stats ignore writes
        i_rlf_host.wr(OFS_PORT_SELECT, 8'h02);
        i_rlf_host.wr(OFS_MBOX_FIRST, 8'haa);
        i_rlf_host.wr(OFS_LINES_LOW, 8'h5a);
        rc(OFS_MBOX_FIRST, 8'haa);
        i_rlf_host.wr(OFS_PORT_SELECT, 8'h01);
        rc(OFS_MBOX_FIRST, 8'h00);
        i_rlf_host.wr(OFS_MBOX_SECOND, 8'h3c);
        rc(OFS_MBOX_SECOND, 8'h3c);
        rc(OFS_LINES_LOW, 8'h00);
        frame(0, 16'h1234, 16'h0567);
        frame(1, 16'h4321, 16'h0765);
        rc(OFS_LINES_HIGH, 8'h12);
        frame(0, 16'habcd, 16'h0789);
        rc(OFS_LINES_LOW, 8'h34);
        rc(OFS_LEN_HIGH, 8'h07);
        frame(0, 16'h1111, 16'h0222);
        rc(OFS_LEN_LOW, 8'h89);
        rc(OFS_LINES_HIGH, 8'h11);
        // freeze while change enables are set
        lines_ie[0] = 1'b1;
        len_ie[0] = 1'b1;
        frame(0, 16'h2222, 16'h0333);
        frame(0, 16'h3333, 16'h0444);
        rc(OFS_LINES_HIGH, 8'h22);
        rc(OFS_LINES_LOW, 8'h22);
        rc(OFS_LEN_HIGH, 8'h03);
        rc(OFS_LEN_LOW, 8'h33);
        frame(0, 16'h4444, 16'h0555);
        rc(OFS_LINES_HIGH, 8'h44);
        rc(OFS_LEN_HIGH, 8'h05);
        i_rlf_host.wr(OFS_PORT_SELECT, 8'h02);
        rc(OFS_LINES_HIGH, 8'h43);
        i_rlf_host.wr(OFS_PORT_SELECT, 8'h01);
        // frequency detector on port 0, hysteresis 3, low limit 5
        samp(8'd100);
        check(freq_held[0], 8'd100);
        samp(8'd103);
        check(freq_held[0], 8'd100);
        samp(8'd104);
        check(freq_held[0], 8'd104);
        samp(8'd4);
        check({7'h00, link_clock_missing[0]}, 8'h01);
        samp(8'd5);
        check({7'h00, link_clock_missing[0]}, 8'h00);
        repeat (12) @(negedge clk);
        check({7'h00, clock_stable[0]}, 8'h01);
        samp(8'd120);
        check({7'h00, clock_stable[0]}, 8'h00);
        // longest dwell code, hysteresis 0
        i_rlf_host.wr(OFS_DETECT_CTL, 8'h35);
        rc(OFS_DETECT_CTL, 8'h35);
        samp(8'd121);
        check(freq_held[0], 8'd121);
        repeat (20) @(negedge clk);
        check({7'h00, clock_stable[0]}, 8'h00);
        repeat (20) @(negedge clk);
        check({7'h00, clock_stable[0]}, 8'h01);
        finish_test();
    end
endmodule
